/* src/ats_regbank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ats_regs.svh"
module ats_regbank (
    input wire logic clk, // Core clock, 10 MHz
    input wire logic arst_n, // Async reset
    input wire logic [9:0] regAddr, // Register address
    input wire logic [7:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [7:0] regRdata, // Read data, cycle after strobe
    input wire logic [7:0] fuseTrimC, // Fused trim, third input
    input wire logic [7:0] fuseTrimD, // Fused trim, fourth input
    input wire logic fuseValid, // Fuse values ready
    input wire logic swapStart, // Background swap request
    input wire logic selRequest, // Undelayed steering select
    output logic [7:0] inputCTermTrim, // Third-input trim
    output logic [7:0] inputDTermTrim, // Fourth-input trim
    output ats_pkg::ats_dither_t ditherCtrl, // Dither controls
    output logic bothSampling, // Both cores sampling
    output logic steerSelect, // Steering select
    output logic swapBusy // Swap in progress
);
    logic [4:0] overlap_q;
    logic [4:0] selDelay_q;
    logic fuseDone_q;
    logic fuseSync1_q;
    logic fuseSync2_q;

    function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
        hit = (a == b);
    endfunction : hit

    // --------------------------------
    // Fuse load, once after reset
    // --------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fuseSync1_q <= 1'b0;
            fuseSync2_q <= 1'b0;
        end else begin
            fuseSync1_q <= fuseValid;
            fuseSync2_q <= fuseSync1_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fuseDone_q <= 1'b0;
            inputCTermTrim <= 8'h00;
            inputDTermTrim <= 8'h00;
        end else begin
            // Fuse copy taken after reset release; a software write beats it
            if (regWr && hit(regAddr, `ATS_ADDR_TRIM_C)) begin
                inputCTermTrim <= regWdata;
            end else if (!fuseDone_q && fuseSync2_q) begin
                inputCTermTrim <= fuseTrimC;
            end
            if (regWr && hit(regAddr, `ATS_ADDR_TRIM_D)) begin
                inputDTermTrim <= regWdata;
            end else if (!fuseDone_q && fuseSync2_q) begin
                inputDTermTrim <= fuseTrimD;
            end
            if (fuseSync2_q) begin
                fuseDone_q <= 1'b1;
            end
        end
    end

    // --------------------------------
    // Delay and dither registers
    // --------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overlap_q <= `ATS_RST_OVERLAP;
            selDelay_q <= `ATS_RST_SELDLY;
            ditherCtrl <= `ATS_RST_DITHER;
        end else if (regWr) begin
            // Reserved upper bits are not stored and read as zero
            if (hit(regAddr, `ATS_ADDR_OVERLAP)) begin
                overlap_q <= regWdata[`ATS_DLY_MSB:0];
            end else if (hit(regAddr, `ATS_ADDR_SELDLY)) begin
                selDelay_q <= regWdata[`ATS_DLY_MSB:0];
            end else if (hit(regAddr, `ATS_ADDR_DITHER)) begin
                ditherCtrl.ditherOn <= regWdata[`ATS_DITH_ON_BIT];
                ditherCtrl.ditherAmplitudeSelect <= regWdata[`ATS_DITH_AMP_BIT];
                ditherCtrl.roundingErrorSelect <= regWdata[`ATS_DITH_ERR_BIT];
            end
        end
    end

    // --------------------------------
    // Read port
    // --------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            if (hit(regAddr, `ATS_ADDR_TRIM_C)) begin
                regRdata <= inputCTermTrim;
            end else if (hit(regAddr, `ATS_ADDR_TRIM_D)) begin
                regRdata <= inputDTermTrim;
            end else if (hit(regAddr, `ATS_ADDR_OVERLAP)) begin
                regRdata <= {3'h0, overlap_q};
            end else if (hit(regAddr, `ATS_ADDR_SELDLY)) begin
                regRdata <= {3'h0, selDelay_q};
            end else if (hit(regAddr, `ATS_ADDR_DITHER)) begin
                regRdata <= {5'h00, ditherCtrl};
            end else begin
                regRdata <= 8'h00;
            end
        end else begin
            regRdata <= 8'h00;
        end
    end

    ats_swap_timer uTimer (
        .clk(clk),
        .arst_n(arst_n),
        .swapStart(swapStart),
        .overlapSet(overlap_q),
        .selDelaySet(selDelay_q),
        .selRequest(selRequest),
        .bothSampling(bothSampling),
        .steerSelect(steerSelect),
        .swapBusy(swapBusy)
    );
endmodule : ats_regbank
`default_nettype wire

/* src/ats_regs.svh */
// What this block does
// - Third-input trim: 8-bit RW, fused reset value
// - Fourth-input trim: 8-bit RW, fused reset value
// - Trim reads return factory value after reset
// - Swap overlap lasts four plus twice setting
// - Overlap field bits 4:0, 0..31, reset 8
// - Select delay bits 4:0, reset 7
// - Select delay applies only during swaps
// - Dither control: three bits, reset zero
// - Bit 0 enables dither injection and subtraction
// - Bit 1 selects large dither amplitude
// - Bit 2 moves rounding error to offset
`ifndef ATS_REGS_SVH
`define ATS_REGS_SVH
`define ATS_ADDR_TRIM_C 10'h080
`define ATS_ADDR_TRIM_D 10'h081
`define ATS_ADDR_OVERLAP 10'h09a
`define ATS_ADDR_SELDLY 10'h09b
`define ATS_ADDR_DITHER 10'h09d
`define ATS_RST_OVERLAP 5'h08
`define ATS_RST_SELDLY 5'h07
`define ATS_RST_DITHER 3'h0
`define ATS_DLY_MSB 4
`define ATS_DITH_ON_BIT 0
`define ATS_DITH_AMP_BIT 1
`define ATS_DITH_ERR_BIT 2
`define ATS_OVERLAP_BASE 7'h04
`endif

/* src/ats_pkg.sv */
package ats_pkg;
    typedef struct packed {
        logic roundingErrorSelect;
        logic ditherAmplitudeSelect;
        logic ditherOn;
    } ats_dither_t;
    typedef enum logic [1:0] {SW_IDLE, SW_OVERLAP, SW_STEER} ats_swap_t;
endpackage : ats_pkg

/* src/ats_swap_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ats_regs.svh"
module ats_swap_timer (
    input wire logic clk, // Core clock
    input wire logic arst_n, // Async reset
    input wire logic swapStart, // Begin a background swap
    input wire logic [4:0] overlapSet, // Overlap setting
    input wire logic [4:0] selDelaySet, // Select delay setting
    input wire logic selRequest, // Undelayed steering select
    output logic bothSampling, // Both cores sample same input
    output logic steerSelect, // Delayed steering select
    output logic swapBusy // Swap in progress
);
    ats_pkg::ats_swap_t state_q;
    logic [6:0] count_q;
    logic [4:0] selDly_q;
    logic selLatched_q;

    // --------------------------------
    // Swap sequencing
    // --------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ats_pkg::SW_IDLE;
            count_q <= 7'h00;
            selDly_q <= 5'h00;
            bothSampling <= 1'b0;
            swapBusy <= 1'b0;
        end else begin
            case (state_q)
                ats_pkg::SW_IDLE: begin
                    if (swapStart) begin
                        // Settings captured here so later writes wait for next swap
                        count_q <= `ATS_OVERLAP_BASE + {1'b0, overlapSet, 1'b0} - 7'h01;
                        selDly_q <= selDelaySet;
                        bothSampling <= 1'b1;
                        swapBusy <= 1'b1;
                        state_q <= ats_pkg::SW_OVERLAP;
                    end
                end
                ats_pkg::SW_OVERLAP: begin
                    if (count_q == 7'h00) begin
                        bothSampling <= 1'b0;
                        count_q <= {2'h0, selDly_q};
                        state_q <= ats_pkg::SW_STEER;
                    end else begin
                        count_q <= count_q - 7'h01;
                    end
                end
                ats_pkg::SW_STEER: begin
                    if (count_q == 7'h00) begin
                        swapBusy <= 1'b0;
                        state_q <= ats_pkg::SW_IDLE;
                    end else begin
                        count_q <= count_q - 7'h01;
                    end
                end
                default: state_q <= ats_pkg::SW_IDLE;
            endcase
        end
    end

    // --------------------------------
    // Steering select
    // --------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            selLatched_q <= 1'b0;
            steerSelect <= 1'b0;
        end else begin
            if (state_q == ats_pkg::SW_IDLE && !swapStart) begin
                steerSelect <= selRequest;
            end else if (state_q == ats_pkg::SW_OVERLAP) begin
                selLatched_q <= selRequest;
            end else if (state_q == ats_pkg::SW_STEER && count_q == 7'h00) begin
                steerSelect <= selLatched_q;
            end
        end
    end
endmodule : ats_swap_timer
`default_nettype wire

/* bench/ats_regbank_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module ats_regbank_monitor (
    input wire logic clk, // Clock
    input wire logic arst_n, // Reset
    input wire logic [9:0] regAddr, // Address
    input wire logic [7:0] regWdata, // Wdata
    input wire logic regWr, // Write
    input wire logic regRd, // Read
    input wire logic [7:0] regRdata, // Rdata
    input wire logic swapStart, // Swap
    input wire logic selRequest, // Select in
    input wire logic [7:0] inputCTermTrim, // Trim C
    input wire logic [7:0] inputDTermTrim, // Trim D
    input wire ats_pkg::ats_dither_t ditherCtrl, // Dither
    input wire logic bothSampling, // Overlap
    input wire logic steerSelect, // Select out
    input wire logic swapBusy // Busy
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rdC; $past(regRd && regAddr == 10'h080) |-> regRdata == $past(inputCTermTrim); endproperty
    a_rdC: assert property (p_rdC) else $error("trim C readback");
    property p_rdD; $past(regRd && regAddr == 10'h081) |-> regRdata == $past(inputDTermTrim); endproperty
    a_rdD: assert property (p_rdD) else $error("trim D readback");
    property p_wrC; $past(regWr && regAddr == 10'h080) |-> inputCTermTrim == $past(regWdata); endproperty
    a_wrC: assert property (p_wrC) else $error("trim C write");
    property p_dith; $past(regWr && regAddr == 10'h09d) |-> ditherCtrl == $past(regWdata[2:0]); endproperty
    a_dith: assert property (p_dith) else $error("dither write");
    property p_start; swapStart && !swapBusy |=> swapBusy && bothSampling; endproperty
    a_start: assert property (p_start) else $error("swap start");
    property p_minOv; $rose(bothSampling) |-> bothSampling[*4]; endproperty
    a_minOv: assert property (p_minOv) else $error("overlap short");
    property p_follow; !swapBusy && !$past(swapBusy) |-> steerSelect == $past(selRequest); endproperty
    a_follow: assert property (p_follow) else $error("select not prompt");
    property p_hold; bothSampling && $past(bothSampling) |-> $stable(steerSelect); endproperty
    a_hold: assert property (p_hold) else $error("select moved");
endmodule : ats_regbank_monitor
bind ats_regbank ats_regbank_monitor u_mon (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .swapStart(swapStart), .selRequest(selRequest), .inputCTermTrim(inputCTermTrim),
    .inputDTermTrim(inputDTermTrim), .ditherCtrl(ditherCtrl), .bothSampling(bothSampling),
    .steerSelect(steerSelect), .swapBusy(swapBusy));
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, fuseValid = 1'b1;
    logic swapStart = 1'b0, selRequest = 1'b0, bothSampling, steerSelect, swapBusy;
    logic [9:0] regAddr = 10'h000;
    logic [7:0] regWdata = 8'h00, regRdata, trimC, trimD;
    ats_pkg::ats_dither_t dith;
    int failCount = 0, nTests = 0, nb = 0, ns = 0;
    always #50 clk = ~clk;
    // Running overlap and select-phase cycle counts
    always @(posedge clk) begin
        nb <= nb + int'(bothSampling);
        ns <= ns + int'(swapBusy & ~bothSampling);
    end
    ats_regbank u_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fuseTrimC(8'h5a),
        .fuseTrimD(8'ha5), .fuseValid(fuseValid), .swapStart(swapStart),
        .selRequest(selRequest), .inputCTermTrim(trimC), .inputDTermTrim(trimD),
        .ditherCtrl(dith), .bothSampling(bothSampling), .steerSelect(steerSelect),
        .swapBusy(swapBusy));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task chk(input string nm, input logic [7:0] e, g);
        nTests++;
        if (g !== e) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk) regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge clk) regWr <= 1'b0;
    endtask : wr
    task rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge clk) regAddr <= a; regRd <= 1'b1;
        @(posedge clk) regRd <= 1'b0;
        @(negedge clk) chk("rdata", e, regRdata);
    endtask : rd
    task t_regs;
        rd(10'h080, 8'h5a);
        rd(10'h081, 8'ha5);
        rd(10'h09a, 8'h08);
        rd(10'h09b, 8'h07);
        rd(10'h09d, 8'h00);
        wr(10'h080, 8'h3c);
        wr(10'h081, 8'hc3);
        @(negedge clk) chk("trimC", 8'h3c, trimC);
        chk("trimD", 8'hc3, trimD);
        rd(10'h080, 8'h3c);
        rd(10'h081, 8'hc3);
        wr(10'h09a, 8'h1f);
        rd(10'h09a, 8'h1f);
        wr(10'h09b, 8'h15);
        rd(10'h09b, 8'h15);
        wr(10'h09c, 8'hff);
        rd(10'h09c, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(10'h09d, 8'(1 << i));
            @(negedge clk) chk("dither", 8'(1 << i), {5'h00, dith});
        end
        chk("ampl", 8'h00, {7'h00, dith.ditherAmplitudeSelect});
        chk("rounding", 8'h01, {7'h00, dith.roundingErrorSelect});
        rd(10'h09d, 8'h04);
    endtask : t_regs
    task t_swap(input logic [4:0] ov, sd);
        int b0, s0;
        wr(10'h09a, {3'h0, ov});
        wr(10'h09b, {3'h0, sd});
        @(posedge clk) swapStart <= 1'b1; selRequest <= ~selRequest; b0 = nb; s0 = ns;
        @(posedge clk) swapStart <= 1'b0;
        // Select must not follow the request once a swap has begun
        @(negedge clk) chk("steerhold", {7'h00, ~selRequest}, {7'h00, steerSelect});
        wr(10'h09a, 8'h00);
        @(posedge clk) swapStart <= 1'b1;
        @(posedge clk) swapStart <= 1'b0;
        repeat (120) @(posedge clk);
        @(negedge clk) chk("overlap", 8'(4 + 2 * ov), 8'(nb - b0));
        chk("selphase", 8'(sd + 1), 8'(ns - s0));
        chk("steer", {7'h00, selRequest}, {7'h00, steerSelect});
    endtask : t_swap
    task t_reset;
        @(posedge clk) arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(10'h080, 8'h5a);
        rd(10'h081, 8'ha5);
        rd(10'h09a, 8'h08);
        rd(10'h09b, 8'h07);
    endtask : t_reset
    task printVerdict;
        $display("tests %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : printVerdict
    initial begin
        #500000;
        failCount++;
        printVerdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_regs();
        t_reset();
        t_swap(5'h00, 5'h00);
        t_swap(5'h1f, 5'h03);
        t_swap(5'h07, 5'h1f);
        printVerdict();
    end
endmodule : tb
`default_nettype wire
